// *** sbw_pkg.sv ***
`default_nettype none
package sbw_pkg;
	localparam int SBW_ADDR_W = 36;
	localparam int SBW_DATA_W = 64;
	localparam int SBW_BE_W = 8;
	localparam int SBW_LINE_BYTES = 32;
	localparam int SBW_BEAT_BYTES = 8;
	localparam int SBW_BEATS = SBW_LINE_BYTES / SBW_BEAT_BYTES;
	localparam int SBW_FIFO_DEPTH = 16;
	localparam logic [SBW_ADDR_W-1:0] SBW_ADDR_STEP = 36'h000000008;
	localparam logic [SBW_ADDR_W-1:0] SBW_LINE_MASK = 36'hfffffffe0;
	localparam logic [1:0] SBW_LAST_IDX = 2'h3;
	localparam logic [1:0] SBW_PENULT_IDX = 2'h2;
endpackage : sbw_pkg
`default_nettype wire

// *** sbw_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module sbw_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import sbw_pkg::*;
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sbw_fifo_st_t;

	sbw_fifo_st_t s_reg, s_next;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic push, pop;

	assign in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_reg.cnt != '0);
	assign out_data = mem_reg[s_reg.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.wp = s_reg.wp + AW'(1);
		end
		if (pop) begin
			s_next.rp = s_reg.rp + AW'(1);
		end
		s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else if (clk_en) begin
			s_reg <= s_next;
			if (push) begin
				mem_reg[s_reg.wp] <= in_data;
			end
		end
	end
endmodule : sbw_fifo
`default_nettype wire

// *** sbw_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module sbw_master #(
	parameter int FIFO_DEPTH = sbw_pkg::SBW_FIFO_DEPTH
) (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Write-back request from the data cache
	input wire logic wb_req,
	output logic wb_req_ready,
	input wire logic [sbw_pkg::SBW_ADDR_W-1:0] wb_addr,
	// Line data stream into the beat buffer
	input wire logic wd_valid,
	output logic wd_ready,
	input wire logic [sbw_pkg::SBW_DATA_W-1:0] wd_data,
	// Single write request
	input wire logic sw_req,
	output logic sw_req_ready,
	input wire logic [sbw_pkg::SBW_ADDR_W-1:0] sw_addr,
	input wire logic [sbw_pkg::SBW_DATA_W-1:0] sw_data,
	input wire logic [sbw_pkg::SBW_BE_W-1:0] sw_be_n,
	// System bus outputs
	output logic [sbw_pkg::SBW_ADDR_W-1:0] bus_address,
	output logic [sbw_pkg::SBW_DATA_W-1:0] write_data_bus,
	output logic [sbw_pkg::SBW_BE_W-1:0] byte_enable_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic cacheable_n,
	output logic fetch_type_flag,
	output logic burst_indicator_n,
	output logic transfer_start_strobe_n,
	output logic last_beat_n,
	// System bus inputs
	input wire logic transfer_ack_n,
	input wire logic bus_error_n,
	// Status
	output logic busy
);
	import sbw_pkg::*;

	typedef enum {SBW_IDLE, SBW_BURST, SBW_SINGLE} sbw_state_t;

	typedef struct packed {
		sbw_state_t st;
		logic [1:0] beat;
		logic [SBW_ADDR_W-1:0] addr;
		logic [SBW_DATA_W-1:0] data;
		logic [SBW_BE_W-1:0] be_n;
		logic wr_n;
		logic cache_n;
		logic id;
		logic burst_n;
		logic start_n;
		logic last_n;
	} sbw_st_t;

	sbw_st_t s_reg, s_next;
	logic f_valid, f_ready;
	logic [SBW_DATA_W-1:0] f_data;
	logic ack, done, may_start, bus_err_unused;

	// ----------------------------------------------------------------
	// Beat buffer
	// ----------------------------------------------------------------
	// Cache must push the whole line before the burst starts, so a
	// beat is never missing mid-burst; the bus cannot stall on data.
	sbw_fifo #(.WIDTH(SBW_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_valid(wd_valid),
		.in_ready(wd_ready),
		.in_data(wd_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// ----------------------------------------------------------------
	// Transfer control
	// ----------------------------------------------------------------
	assign ack = !transfer_ack_n;
	assign bus_err_unused = bus_error_n;
	assign done = (s_reg.st == SBW_SINGLE && ack) ||
		(s_reg.st == SBW_BURST && ack && s_reg.beat == SBW_LAST_IDX);
	assign may_start = (s_reg.st == SBW_IDLE) || done;
	// Burst launches once at least one beat is buffered
	assign wb_req_ready = may_start && f_valid;
	assign sw_req_ready = may_start && !(wb_req && f_valid);
	// Pop the beat loaded on each burst ack but the last, and the first on launch;
	// popping on the final ack would lose the first beat of a buffered next line
	assign f_ready = (s_reg.st == SBW_BURST && ack && s_reg.beat != SBW_LAST_IDX)
		|| (wb_req && wb_req_ready);

	always_comb begin
		s_next = s_reg;
		s_next.start_n = 1'b1;
		if (s_reg.st == SBW_BURST && ack) begin
			s_next.beat = s_reg.beat + 2'h1;
			s_next.addr = s_reg.addr + SBW_ADDR_STEP;
			s_next.data = f_data;
			if (s_reg.beat == SBW_PENULT_IDX) begin
				s_next.last_n = 1'b0;
			end
			if (s_reg.beat == SBW_LAST_IDX) begin
				s_next.last_n = 1'b1;
			end
		end
		if (s_reg.st == SBW_SINGLE && ack) begin
			s_next.last_n = 1'b1;
		end
		if (done) begin
			// Ends here unless a launch below overrides it in the same cycle
			s_next.st = SBW_IDLE;
			s_next.be_n = '1;
			s_next.wr_n = 1'b1;
			s_next.cache_n = 1'b1;
			s_next.id = 1'b1;
			s_next.burst_n = 1'b1;
			s_next.last_n = 1'b1;
		end
		if (may_start && wb_req && f_valid) begin
			// Launch straight from the final ack keeps the write strobe low and drops the start strobe again
			s_next.st = SBW_BURST;
			s_next.beat = 2'h0;
			s_next.addr = wb_addr & SBW_LINE_MASK;
			s_next.data = f_data;
			s_next.be_n = '0;
			s_next.cache_n = 1'b0;
			s_next.id = 1'b0;
			s_next.wr_n = 1'b0;
			s_next.burst_n = 1'b0;
			s_next.start_n = 1'b0;
			s_next.last_n = 1'b1;
		end else if (may_start && sw_req) begin
			// Write strobe stays low across the join
			s_next.st = SBW_SINGLE;
			s_next.addr = sw_addr;
			s_next.data = sw_data;
			s_next.be_n = sw_be_n;
			s_next.cache_n = 1'b1;
			s_next.id = 1'b0;
			s_next.wr_n = 1'b0;
			s_next.burst_n = 1'b1;
			s_next.start_n = 1'b0;
			s_next.last_n = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			// Idle levels during reset
			s_reg <= '{st: SBW_IDLE, beat: 2'h0, addr: '0, data: '0, be_n: '1,
				wr_n: 1'b1, cache_n: 1'b1, id: 1'b1, burst_n: 1'b1,
				start_n: 1'b1, last_n: 1'b1};
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_address = s_reg.addr;
	assign write_data_bus = s_reg.data;
	assign byte_enable_n = s_reg.be_n;
	assign read_strobe_n = 1'b1;
	assign write_strobe_n = s_reg.wr_n;
	assign cacheable_n = s_reg.cache_n;
	assign fetch_type_flag = s_reg.id;
	assign burst_indicator_n = s_reg.burst_n;
	assign transfer_start_strobe_n = s_reg.start_n;
	assign last_beat_n = s_reg.last_n;
	assign busy = (s_reg.st != SBW_IDLE);

	// ----------------------------------------------------------------
	// Checks: start of a transfer
	// ----------------------------------------------------------------
	// No disable here: the idle levels must show while reset is held
	reset_idle_a: assert property (@(posedge sys_clk)
		!rst_n |=> byte_enable_n == '1 && write_strobe_n && read_strobe_n && cacheable_n &&
		fetch_type_flag && burst_indicator_n && transfer_start_strobe_n && last_beat_n)
		else $error("reset outputs not at idle levels");

	start_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(transfer_start_strobe_n) && clk_en |=> transfer_start_strobe_n)
		else $error("start strobe held too long");

	start_group_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!transfer_start_strobe_n && s_reg.st == SBW_BURST |->
		!write_strobe_n && !burst_indicator_n && s_reg.beat == 2'h0)
		else $error("burst start signals not together");

	start_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!transfer_start_strobe_n |-> !write_strobe_n && busy)
		else $error("start strobe without write strobe");

	line_base_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!transfer_start_strobe_n && s_reg.st == SBW_BURST |->
		bus_address[4:0] == 5'h00)
		else $error("burst not at line base");

	data_type_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_reg.st != SBW_IDLE |-> !fetch_type_flag)
		else $error("fetch-type flag high during write");

	// ----------------------------------------------------------------
	// Checks: beats
	// ----------------------------------------------------------------
	// Address bits track the beat, so a lost or extra ack shows as a wrong step
	burst_levels_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_reg.st == SBW_BURST |-> byte_enable_n == '0 && !cacheable_n && !fetch_type_flag)
		else $error("burst byte enables or cacheable not low");

	addr_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && s_reg.st == SBW_BURST && ack && s_reg.beat != SBW_LAST_IDX |=>
		bus_address == $past(bus_address) + SBW_ADDR_STEP)
		else $error("address did not step by eight");

	addr_beat_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_reg.st == SBW_BURST |-> bus_address[4:3] == s_reg.beat)
		else $error("address does not match beat");

	data_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && s_reg.st == SBW_BURST && ack && s_reg.beat != SBW_LAST_IDX |=>
		write_data_bus == $past(f_data))
		else $error("next beat data not presented");

	wait_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && s_reg.st == SBW_BURST && !ack |=>
		$stable(bus_address) && $stable(write_data_bus))
		else $error("beat changed during wait");

	wait_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && busy && !ack |=> !write_strobe_n && busy)
		else $error("write strobe dropped during wait");

	err_ignored_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && busy && !ack && !bus_error_n |=> busy && $stable(write_strobe_n))
		else $error("bus error ended a write");

	last_early_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_reg.st == SBW_BURST && s_reg.beat != SBW_LAST_IDX |-> last_beat_n)
		else $error("last beat asserted too early");

	last_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && s_reg.st == SBW_BURST && ack && s_reg.beat == SBW_PENULT_IDX |=>
		!last_beat_n)
		else $error("last beat not asserted");

	// ----------------------------------------------------------------
	// Checks: end, joins and idle
	// ----------------------------------------------------------------
	// A join must not leave a one-cycle gap on the write strobe
	last_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && s_reg.st == SBW_BURST && done && !(wb_req && f_valid) && !sw_req |=>
		last_beat_n && write_strobe_n && burst_indicator_n)
		else $error("burst did not end after final ack");

	busy_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		busy |-> !write_strobe_n)
		else $error("write strobe high during transfer");

	chain_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && done && wb_req && f_valid |=> !write_strobe_n && !burst_indicator_n)
		else $error("chained burst dropped strobe");

	chain_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && done && wb_req && f_valid |=> !transfer_start_strobe_n &&
		bus_address[4:0] == 5'h00)
		else $error("chained burst did not restart");

	single_join_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clk_en && s_reg.st == SBW_BURST && done && sw_req && !(wb_req && f_valid) |=>
		!write_strobe_n && !transfer_start_strobe_n && burst_indicator_n)
		else $error("single write did not join burst");

	single_levels_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_reg.st == SBW_SINGLE |-> burst_indicator_n && cacheable_n)
		else $error("single write shows burst levels");

	idle_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_reg.st == SBW_IDLE |-> byte_enable_n == '1 && write_strobe_n &&
		read_strobe_n && cacheable_n && fetch_type_flag && burst_indicator_n &&
		transfer_start_strobe_n && last_beat_n)
		else $error("idle outputs not high");
endmodule : sbw_master
`default_nettype wire

// *** sbw_ack_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---
// Acknowledge responder
// ---
module sbw_ack_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Pacing: high inserts random waits
	input wire logic slow,
	// Bus from master
	input wire logic write_strobe_n,
	input wire logic transfer_start_strobe_n,
	// Answer
	output logic transfer_ack_n
);
	logic go_reg;
	// Wait decision only changes on rising edges
	always_ff @(posedge sys_clk) begin
		go_reg <= !rst_n || !slow || $urandom_range(1, 0) == 1;
	end
	// Every beat is acked, faulty ones too; pulled high outside a transfer
	assign transfer_ack_n = !(go_reg && !write_strobe_n && transfer_start_strobe_n);
endmodule : sbw_ack_model
`default_nettype wire

// *** sbw_master_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module sbw_master_bench;
	import sbw_pkg::*;
	logic sys_clk = 0, rst_n = 0, slow = 0, bus_error_n = 1;
	logic wb_req = 0, wd_valid = 0, sw_req = 0;
	logic [SBW_ADDR_W-1:0] wb_addr = '0, sw_addr = '0, ba;
	logic [SBW_DATA_W-1:0] wd_data = '0, sw_data = '0, wdb;
	logic [SBW_BE_W-1:0] sw_be_n = '0, ben;
	logic rd_n, wr_n, ca_n, ft, bu_n, st_n, la_n, ack_n, wbr, wdr, swr, busy;
	logic [108:0] eq[$];
	logic [108:0] e;
	logic [99:0] pv;
	logic pwr = 1, pack = 1, pst = 1, ce = 1, pce = 1;
	int bad_count = 0, check_count = 0, idx = 0, chain = 0, c0;
	logic [35:0] a;
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) bus_error_n <= #1 1'($urandom);
	sbw_master i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce), .wb_req(wb_req),
		.wb_req_ready(wbr), .wb_addr(wb_addr), .wd_valid(wd_valid), .wd_ready(wdr),
		.wd_data(wd_data), .sw_req(sw_req), .sw_req_ready(swr), .sw_addr(sw_addr),
		.sw_data(sw_data), .sw_be_n(sw_be_n), .bus_address(ba), .write_data_bus(wdb),
		.byte_enable_n(ben), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .cacheable_n(ca_n),
		.fetch_type_flag(ft), .burst_indicator_n(bu_n), .transfer_start_strobe_n(st_n),
		.last_beat_n(la_n), .transfer_ack_n(ack_n), .bus_error_n(bus_error_n), .busy(busy));
	sbw_ack_model i_ack (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .write_strobe_n(wr_n),
		.transfer_start_strobe_n(st_n), .transfer_ack_n(ack_n));
	task chk(input logic [108:0] g, input logic [108:0] x);
		check_count++;
		if (g !== x) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	task tick;
		@(posedge sys_clk);
		#1;
		ce = ($urandom_range(7, 0) != 0);
	endtask : tick
	// Bounded wait: 0 buffer, 1 burst take, 2 single take, 3 all done;
	// a take also needs the enable high at the coming edge
	task await(input int w);
		int n;
		n = 0;
		while (!(w == 0 ? wdr && ce : w == 1 ? wbr && ce : w == 2 ? swr && ce :
			!busy && eq.size() == 0)) begin
			if (n++ > 300) begin
				bad_count++;
				complete_run();
			end
			tick();
		end
	endtask : await
	task idle_chk;
		chk({ben, rd_n, wr_n, ca_n, ft, bu_n, st_n, la_n}, 15'h7fff);
	endtask : idle_chk
	// Pushes n whole lines; the bus must show them base first, eight apart
	task line(input logic [35:0] s, input int n);
		wd_valid = 1;
		for (int i = 0; i < n * SBW_BEATS; i++) begin
			wd_data = {$urandom, $urandom};
			eq.push_back({9'h0, (s & SBW_LINE_MASK) + 36'h8 * i, wd_data});
			await(0);
			tick();
		end
		wd_valid = 0;
	endtask : line
	task req(input logic [35:0] s);
		wb_addr = s;
		wb_req = 1;
		await(1);
		tick();
	endtask : req
	// ---
	// Bus monitor
	// ---
	// Falling edge: registered outputs have settled, and the ack seen here is
	// the one the design takes at the next rising edge if the enable is high
	always @(negedge sys_clk) begin
		if (rst_n) begin
			if (!st_n && pst) begin
				chk({wr_n, ft, bu_n, la_n}, {2'b0, eq[0][108], !eq[0][108]});
				if (!pwr) chain++;
			end
			if (!pst && pce) chk(st_n, 1);
			if (!pwr && (pack || !pce)) chk({ba, wdb}, pv);
			if (!wr_n && !ack_n && ce) begin
				e = eq.pop_front();
				chk({ca_n, ben, ba, wdb}, e);
				chk({ft, bu_n, la_n}, {1'b0, e[108], !e[108] && idx != 3});
				idx = e[108] ? 0 : (idx + 1) % SBW_BEATS;
			end
		end
		pwr <= wr_n;
		pack <= ack_n;
		pst <= st_n;
		pce <= ce;
		pv <= {ba, wdb};
	end
	initial begin
		void'($urandom(32'h2d9a5a8a));
		repeat (10) tick();
		idle_chk();
		repeat (10) tick();
		rst_n = 1;
		tick();
		idle_chk();
		$display("test reset done");
		for (int t = 0; t < 12; t++) begin
			slow = t[0];
			a = t == 0 ? '1 : {4'($urandom), $urandom};
			line(a, 1);
			req(a);
			wb_req = 0;
			await(3);
			idle_chk();
		end
		$display("test bursts done");
		// Two bursts then a single, all back to back
		c0 = chain;
		slow = 1;
		line(a, 2);
		req(a);
		req(a + 36'h20);
		wb_req = 0;
		sw_addr = {4'($urandom), $urandom};
		sw_data = {$urandom, $urandom};
		sw_be_n = 8'($urandom);
		sw_req = 1;
		eq.push_back({1'b1, sw_be_n, sw_addr, sw_data});
		await(2);
		tick();
		sw_req = 0;
		await(3);
		chk(chain - c0, 2);
		$display("test chained done");
		// Fill the buffer until it refuses, then drain with a slow far side
		line(a, 4);
		chk(wdr, 0);
		for (int k = 0; k < 4; k++) req(a + 36'h20 * k);
		wb_req = 0;
		await(3);
		chk(wdr, 1);
		idle_chk();
		$display("test buffer done");
		complete_run();
	end
endmodule : sbw_master_bench
`default_nettype wire
